// *** hw/fccs_pkg.sv ***
// Constants of the command, configuration and status block.
package fccs_pkg;
    // ==========================================================
    // Command word fields
    localparam int OPC_LSB = 8;
    localparam int OPC_MSB = 11;
    localparam int OPR_MSB = 2;
    // ==========================================================
    // Opcodes
    localparam logic [3:0] OPC_RESET    = 4'h0;
    localparam logic [3:0] OPC_SEL_CFG  = 4'h1;
    localparam logic [3:0] OPC_DMA_DIR  = 4'h6;
    localparam logic [3:0] OPC_STAT_FMT = 4'h7;
    localparam logic [3:0] OPC_CLR_WPE  = 4'hA;
    localparam logic [3:0] OPC_CLR_RPE  = 4'hB;
    // ==========================================================
    // Reset operands
    localparam logic [2:0] RST_BA  = 3'h1;
    localparam logic [2:0] RST_AB  = 3'h2;
    localparam logic [2:0] RST_ALL_PTR = 3'h3;
    localparam logic [2:0] RST_DMA = 3'h4;
    localparam logic [2:0] RST_ALL = 3'h7;
    // ==========================================================
    // Port A address decode {a1,a0}
    localparam logic [1:0] ADDR_CFG  = 2'h2;
    localparam logic [1:0] ADDR_CMD  = 2'h3;
    // ==========================================================
    // Configuration register indices
    localparam logic [2:0] CFG_AB_AE   = 3'h0;
    localparam logic [2:0] CFG_AB_AF   = 3'h1;
    localparam logic [2:0] CFG_BA_AE   = 3'h2;
    localparam logic [2:0] CFG_BA_AF   = 3'h3;
    localparam logic [2:0] CFG_ROUTE   = 3'h4;
    localparam logic [2:0] CFG_GEN_CTL = 3'h5;
    localparam logic [2:0] CFG_PARITY  = 3'h7;
    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_OFFSET = 16'h0000;
    localparam logic [15:0] RST_ROUTE  = 16'h6420;
    localparam logic [15:0] RST_GEN    = 16'h0000;
    localparam logic [15:0] RST_PAR    = 16'h0000;
    localparam logic        RST_FMT    = 1'b0;
    localparam logic        RST_DIR    = 1'b0;
    // ==========================================================
    // General control bit positions
    localparam int GC_STYLE    = 0;
    localparam int GC_SWAP     = 1;
    localparam int GC_RR_FULL  = 2;
    localparam int GC_RW_EMPTY = 3;
    localparam int GC_REQ_POL  = 4;
    localparam int GC_ACK_POL  = 5;
    localparam int GC_ACK_LSB  = 6;
    localparam int GC_ACK_MSB  = 7;
    localparam int GC_STB_LEN  = 8;
    localparam int GC_CLK_DIV  = 9;
    localparam int GC_PERIPH   = 10;
    localparam int GC_WID_LSB  = 11;
    localparam int GC_WID_MSB  = 12;
    // Parity control: parity error drives flag pin 0
    localparam int PC_ERR_PIN0 = 11;
    // ==========================================================
    // Internal flag indices (assignment code low three bits)
    localparam int FL_AB_E  = 0;
    localparam int FL_AB_AE = 1;
    localparam int FL_AB_F  = 2;
    localparam int FL_AB_AF = 3;
    localparam int FL_BA_E  = 4;
    localparam int FL_BA_AE = 5;
    localparam int FL_BA_F  = 6;
    localparam int FL_BA_AF = 7;
    // Offsets use 10 bits; bit 9 written zero on the shallow variant
    localparam int OFS_W = 10;
endpackage : fccs_pkg

// *** hw/fccs_top.sv ***
// Port A command decode, configuration registers and status word.
`timescale 1ns/1ps
module fccs_top
    import fccs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        hard_reset_n,
    input  wire logic        host_port_select_n,
    input  wire logic        host_addr_bit_high,
    input  wire logic        host_addr_bit_low,
    input  wire logic        host_read,
    input  wire logic        host_data_strobe_n,
    input  wire logic [15:0] host_data_in,
    output logic      [15:0] host_data_out,
    output logic             host_data_oe,
    input  wire logic [7:0]  internal_flags,
    input  wire logic [7:0]  odd_byte_data,
    input  wire logic        odd_byte_load,
    input  wire logic        write_parity_err_set,
    input  wire logic        read_parity_err_set,
    input  wire logic        dma_clk_in,
    output logic             ba_ptr_clear,
    output logic             ab_ptr_clear,
    output logic             dma_req_clear,
    output logic             odd_byte_valid,
    output logic             dma_dir_read_ab,
    output logic             status_format,
    output logic             dma_tick,
    output logic [OFS_W-1:0] ab_ae_offset,
    output logic [OFS_W-1:0] ab_af_offset,
    output logic [OFS_W-1:0] ba_ae_offset,
    output logic [OFS_W-1:0] ba_af_offset,
    output logic [15:0]      general_control,
    output logic [15:0]      parity_control,
    output logic [3:0]       flag_pins
);
    // ==========================================================
    // Pin synchronisers
    localparam int SW = 23;
    logic [SW-1:0] sync1_r;
    logic [SW-1:0] sync2_r;
    logic          ds_d_r;
    logic          dclk_d_r;
    logic [15:0]   gen_r;
    wire  [SW-1:0] pins_in = {dma_clk_in, hard_reset_n, host_port_select_n,
                              host_addr_bit_high, host_addr_bit_low,
                              host_read, host_data_strobe_n, host_data_in};

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r  <= '1;
            sync2_r  <= '1;
            ds_d_r   <= 1'b1;
            dclk_d_r <= 1'b1;
        end else begin
            sync1_r  <= pins_in;
            sync2_r  <= sync1_r;
            ds_d_r   <= sync2_r[16];
            dclk_d_r <= sync2_r[22];
        end
    end

    // Data bus is sampled only on the strobe edge, by then it is stable
    wire [15:0] s_data  = sync2_r[15:0];
    wire        s_ds_n  = sync2_r[16];
    wire        s_read  = sync2_r[17];
    wire [1:0]  s_addr  = sync2_r[19:18];
    wire        s_cs_n  = sync2_r[20];
    wire        hw_rst  = ~sync2_r[21];
    wire        s_dclk  = sync2_r[22];

    // ==========================================================
    // Access decode
    wire ds_fall  = ds_d_r & ~s_ds_n;
    wire wr_evt   = ds_fall & ~s_cs_n & ~s_read;
    wire cmd_wr   = wr_evt & (s_addr == ADDR_CMD);
    wire cfg_wr   = wr_evt & (s_addr == ADDR_CFG);
    wire rd_act   = ~s_cs_n & s_read & ~s_ds_n & s_addr[1];
    wire stat_rd  = s_addr == ADDR_CMD;

    wire [3:0] opc = s_data[OPC_MSB:OPC_LSB];
    wire [2:0] opr = s_data[OPR_MSB:0];
    wire is_rst   = cmd_wr & (opc == OPC_RESET);
    wire rst_ba   = is_rst & ((opr == RST_BA) | (opr == RST_ALL_PTR)
                    | (opr == RST_ALL));
    wire rst_ab   = is_rst & ((opr == RST_AB) | (opr == RST_ALL_PTR)
                    | (opr == RST_ALL));
    wire rst_dma  = is_rst & ((opr == RST_DMA) | (opr == RST_ALL));
    wire rst_all  = is_rst & (opr == RST_ALL);
    wire clr_val  = rst_ba;
    wire sel_cmd  = cmd_wr & (opc == OPC_SEL_CFG);
    wire dir_cmd  = cmd_wr & (opc == OPC_DMA_DIR)
                    & gen_r[GC_PERIPH];
    wire fmt_cmd  = cmd_wr & (opc == OPC_STAT_FMT);
    wire clr_wpe  = cmd_wr & (opc == OPC_CLR_WPE);
    wire clr_rpe  = cmd_wr & (opc == OPC_CLR_RPE);

    // ==========================================================
    // Registers
    logic [15:0] cfg_r [0:3];
    logic [15:0] route_r;
    logic [15:0] par_r;
    logic [2:0]  sel_r;
    logic        fmt_r;
    logic        dir_r;
    logic        valid_r;
    logic        wpe_r;
    logic        rpe_r;
    logic        ba_clr_r;
    logic        ab_clr_r;
    logic        dma_clr_r;

    // Configuration: hardware reset or reset-all restores defaults
    wire cfg_dflt = hw_rst | rst_all;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ofs
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n)
                    cfg_r[gi] <= RST_OFFSET;
                else if (cfg_dflt)
                    cfg_r[gi] <= RST_OFFSET;
                else if (cfg_wr && sel_r == 3'(gi))
                    cfg_r[gi] <= s_data;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            route_r <= RST_ROUTE;
            gen_r   <= RST_GEN;
            par_r   <= RST_PAR;
        end else if (cfg_dflt) begin
            route_r <= RST_ROUTE;
            gen_r   <= RST_GEN;
            par_r   <= RST_PAR;
        end else if (cfg_wr) begin
            if (sel_r == CFG_ROUTE)
                route_r <= s_data;
            if (sel_r == CFG_GEN_CTL)
                gen_r <= s_data;
            if (sel_r == CFG_PARITY)
                par_r <= s_data;
        end
    end

    // Format, direction, parity flags: hardware reset clears them; software reset does not
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_r <= 3'h0;
            fmt_r <= RST_FMT;
            dir_r <= RST_DIR;
            wpe_r <= 1'b0;
            rpe_r <= 1'b0;
        end else if (hw_rst) begin
            sel_r <= 3'h0;
            fmt_r <= RST_FMT;
            dir_r <= RST_DIR;
            wpe_r <= 1'b0;
            rpe_r <= 1'b0;
        end else begin
            if (sel_cmd)
                sel_r <= opr;
            if (fmt_cmd)
                fmt_r <= opr[0];
            if (dir_cmd)
                dir_r <= opr[0];
            // Set wins over a clear arriving in the same cycle
            wpe_r <= write_parity_err_set | (wpe_r & ~clr_wpe);
            rpe_r <= read_parity_err_set | (rpe_r & ~clr_rpe);
        end
    end

    // Odd byte valid and clear pulses to the datapath: one cycle per reset command, held while hardware reset lasts
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_r   <= 1'b0;
            ba_clr_r  <= 1'b0;
            ab_clr_r  <= 1'b0;
            dma_clr_r <= 1'b0;
        end else begin
            valid_r   <= odd_byte_load
                         | (valid_r & ~clr_val & ~hw_rst);
            ba_clr_r  <= rst_ba | hw_rst;
            ab_clr_r  <= rst_ab | hw_rst;
            dma_clr_r <= rst_dma | hw_rst;
        end
    end

    // ==========================================================
    // DMA tick: external clock edge, optionally halved
    logic div_r;
    logic tick_r;
    wire  dclk_rise = s_dclk & ~dclk_d_r;
    wire  periph    = gen_r[GC_PERIPH];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_r  <= 1'b0;
            tick_r <= 1'b0;
        end else begin
            if (dclk_rise)
                div_r <= ~div_r;
            // Tick only matters in peripheral mode; gated there
            tick_r <= periph & dclk_rise
                      & (~gen_r[GC_CLK_DIV] | div_r);
        end
    end

    // ==========================================================
    // Status word and flag pins
    wire [7:0] stat_lo = fmt_r ?
        {internal_flags[FL_BA_AF], internal_flags[FL_BA_F],
         internal_flags[FL_AB_AE], internal_flags[FL_AB_E],
         dir_r, 3'h0} : odd_byte_data;
    wire [7:0] stat_hi = {internal_flags[FL_BA_AE], internal_flags[FL_BA_E],
                          internal_flags[FL_AB_AF], internal_flags[FL_AB_F],
                          fmt_r, rpe_r, wpe_r, valid_r};
    wire [15:0] stat_w = {stat_hi, stat_lo};

    // Register 6 is reserved and reads zero
    wire [15:0] cfg_rd = (sel_r <= CFG_BA_AF) ? cfg_r[sel_r[1:0]] :
                         (sel_r == CFG_ROUTE) ? route_r :
                         (sel_r == CFG_GEN_CTL) ? gen_r :
                         (sel_r == CFG_PARITY) ? par_r : 16'h0000;

    // Code bit 3 selects true level; codes 0-7 drive the inverted flag
    logic [3:0] pin_w;
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            pin_w[p] = internal_flags[route_r[4*p +: 3]]
                       ^ ~route_r[4*p+3];
        end
        if (par_r[PC_ERR_PIN0])
            pin_w[0] = wpe_r | rpe_r;
    end

    logic [15:0] dout_r;
    logic        oe_r;
    logic [3:0]  pins_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dout_r <= 16'h0000;
            oe_r   <= 1'b0;
            pins_r <= 4'h0;
        end else begin
            dout_r <= stat_rd ? stat_w : cfg_rd;
            oe_r   <= rd_act;
            pins_r <= pin_w;
        end
    end

    // ==========================================================
    // Outputs
    assign host_data_out   = dout_r;
    assign host_data_oe    = oe_r;
    assign ba_ptr_clear    = ba_clr_r;
    assign ab_ptr_clear    = ab_clr_r;
    assign dma_req_clear   = dma_clr_r;
    assign odd_byte_valid  = valid_r;
    assign dma_dir_read_ab = dir_r;
    assign status_format   = fmt_r;
    assign dma_tick        = tick_r;
    assign ab_ae_offset    = cfg_r[0][OFS_W-1:0];
    assign ab_af_offset    = cfg_r[1][OFS_W-1:0];
    assign ba_ae_offset    = cfg_r[2][OFS_W-1:0];
    assign ba_af_offset    = cfg_r[3][OFS_W-1:0];
    // Bits 8,7:6,4,5,12:11 feed Port B timing, polarity, width logic
    assign general_control = gen_r;
    assign parity_control  = par_r;
    assign flag_pins       = pins_r;

    // ==========================================================
    // Checks
    ptr_clr_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rst_ab |=> ab_clr_r && $stable(fmt_r))
        else $error("A-to-B clear missing");
    ba_clr_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (is_rst && opr == RST_AB && !hw_rst) |=> !ba_clr_r)
        else $error("B-to-A cleared by A-to-B reset");
    dma_only_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (is_rst && opr == RST_DMA && !hw_rst)
        |=> dma_clr_r && !ab_clr_r && !ba_clr_r)
        else $error("DMA reset wrong scope");
    all_dflt_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        rst_all |=> route_r == RST_ROUTE && gen_r == RST_GEN
        && cfg_r[1] == RST_OFFSET
        && (!valid_r || $past(odd_byte_load)))
        else $error("Reset all left config");
    sw_keep_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (is_rst && !hw_rst)
        |=> $stable(dir_r) && $stable(fmt_r) && $stable(sel_r))
        else $error("Software reset touched format");
    hw_dflt_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        hw_rst |=> route_r == RST_ROUTE && !fmt_r && !dir_r
        && !wpe_r && !rpe_r && (!valid_r || $past(odd_byte_load)))
        else $error("Hardware reset state wrong");
    hw_pulse_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        hw_rst |=> ba_clr_r && ab_clr_r && dma_clr_r && sel_r == 3'h0)
        else $error("Hardware reset clears missing");
    valid_clr_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (clr_val && !odd_byte_load) |=> !valid_r)
        else $error("Valid bit not cleared");
    valid_keep_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (is_rst && opr == RST_AB && valid_r && !hw_rst) |=> valid_r)
        else $error("Valid bit cleared by A-to-B reset");
    sel_idx_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (sel_cmd && !hw_rst) |=> sel_r == $past(opr))
        else $error("Select index wrong");
    dir_gate_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (cmd_wr && opc == OPC_DMA_DIR && !gen_r[GC_PERIPH] && !hw_rst)
        |=> $stable(dir_r))
        else $error("Direction set in processor mode");
    fmt_set_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (fmt_cmd && !hw_rst) |=> fmt_r == $past(opr[0]))
        else $error("Format select wrong");
    ofs_wr_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (cfg_wr && sel_r == CFG_AB_AE && !hw_rst)
        |=> ab_ae_offset == $past(s_data[OFS_W-1:0]))
        else $error("Offset write lost");
    stat_rd_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (stat_rd && !hw_rst) |=> dout_r[11] == $past(fmt_r)
        && dout_r[8] == $past(valid_r))
        else $error("Status format bit wrong");
    tick_half_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (tick_r && gen_r[GC_CLK_DIV] && $stable(gen_r)) |-> !div_r)
        else $error("Divided tick phase wrong");
    tick_proc_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        !gen_r[GC_PERIPH] |=> !tick_r)
        else $error("DMA tick in processor mode");
    undef_op_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (cmd_wr && opc[3:2] == 2'b11 && !hw_rst)
        |=> $stable(sel_r) && $stable(route_r))
        else $error("Undefined opcode changed state");

endmodule : fccs_top

// *** verif/fccs_host_model.sv ***
// Host processor model on the Port A register interface.
`timescale 1ns/1ps
module fccs_host_model
    import fccs_pkg::*;
(
    input  wire logic        sys_clk,
    output logic             host_port_select_n,
    output logic             host_addr_bit_high,
    output logic             host_addr_bit_low,
    output logic             host_read,
    output logic             host_data_strobe_n,
    output logic [15:0]      host_data_in,
    input  wire logic [15:0] host_data_out
);
    // ==========================================================
    // Bus cycle
    initial begin
        host_port_select_n = 1'b1;
        host_addr_bit_high = 1'b0;
        host_addr_bit_low  = 1'b0;
        host_read          = 1'b1;
        host_data_strobe_n = 1'b1;
        host_data_in       = 16'h5A5A;
    end
    task automatic access(input logic [1:0] addr, input logic rd,
                          input logic [15:0] wd, output logic [15:0] q);
        @(negedge sys_clk);
        host_port_select_n = 1'b0;
        {host_addr_bit_high, host_addr_bit_low} = addr;
        host_read    = rd;
        host_data_in = wd;
        @(negedge sys_clk);
        host_data_strobe_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        q = host_data_out;
        host_data_strobe_n = 1'b1;
        @(negedge sys_clk);
        // Released data shows the inverse, not a stale copy
        host_port_select_n = 1'b1;
        host_data_in       = ~wd;
        repeat (4) @(negedge sys_clk);
    endtask : access
    // Junk in the ignored bits shows they are ignored
    task automatic cmd(input logic [3:0] opc, input logic [2:0] opr);
        logic [15:0] q;
        access(ADDR_CMD, 1'b0, {4'hF, opc, 5'h1F, opr}, q);
    endtask : cmd
endmodule : fccs_host_model

// *** verif/tb_top.sv ***
// Self-checking testbench of the command, configuration and status block.
`timescale 1ns/1ps
module tb_top
    import fccs_pkg::*;
;
    logic        sys_clk, rst_n, hard_reset_n, sel_n, a_hi, a_lo, rd, stb_n;
    logic        odd_load, wpe_set, rpe_set, dma_clk, oe, tick;
    logic        ba_clr, ab_clr, dma_clr, valid, dir, fmt;
    logic [15:0] din, dout, gc, pc, q;
    logic [7:0]  flags, odd_data;
    logic [9:0]  ofs [4];
    logic [3:0]  pins;
    int          failures, check_count, n_ba, n_ab, n_dma, n_tick, n_oe;
    // ==========================================================
    // Instances
    fccs_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .hard_reset_n(hard_reset_n), .host_port_select_n(sel_n),
        .host_addr_bit_high(a_hi), .host_addr_bit_low(a_lo),
        .host_read(rd), .host_data_strobe_n(stb_n), .host_data_in(din),
        .host_data_out(dout), .host_data_oe(oe), .internal_flags(flags),
        .odd_byte_data(odd_data), .odd_byte_load(odd_load),
        .write_parity_err_set(wpe_set), .read_parity_err_set(rpe_set),
        .dma_clk_in(dma_clk), .ba_ptr_clear(ba_clr), .ab_ptr_clear(ab_clr),
        .dma_req_clear(dma_clr), .odd_byte_valid(valid),
        .dma_dir_read_ab(dir), .status_format(fmt), .dma_tick(tick),
        .ab_ae_offset(ofs[0]), .ab_af_offset(ofs[1]),
        .ba_ae_offset(ofs[2]), .ba_af_offset(ofs[3]),
        .general_control(gc), .parity_control(pc), .flag_pins(pins));
    fccs_host_model i_host (.sys_clk(sys_clk), .host_port_select_n(sel_n),
        .host_addr_bit_high(a_hi), .host_addr_bit_low(a_lo),
        .host_read(rd), .host_data_strobe_n(stb_n), .host_data_in(din),
        .host_data_out(dout));
    // ==========================================================
    // Clocks and clear, tick and enable counters
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    initial begin
        dma_clk = 1'b0;
        forever begin
            repeat (3) @(negedge sys_clk);
            dma_clk = ~dma_clk;
        end
    end
    always @(posedge sys_clk) begin
        n_ba  += int'(ba_clr);
        n_ab  += int'(ab_clr);
        n_dma += int'(dma_clr);
        n_tick += int'(tick);
        n_oe  += int'(oe);
    end
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                         input string what);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic pulse(ref logic s);
        @(negedge sys_clk) s = 1'b1;
        @(negedge sys_clk) s = 1'b0;
    endtask : pulse
    task automatic cfg(input logic [2:0] i, input logic r,
                       input logic [15:0] v);
        i_host.cmd(OPC_SEL_CFG, i);
        i_host.access(ADDR_CFG, r, v, q);
    endtask : cfg
    task automatic stat();
        n_oe = 0;
        i_host.access(ADDR_CMD, 1'b1, 16'h0000, q);
        check(16'(n_oe), 16'h0006, "oe while strobe low");
    endtask : stat
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : final_report
    // ==========================================================
    // Scenarios
    task automatic t_defaults();
        logic [15:0] d [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                               16'h6420, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 8; i++) begin
            cfg(3'(i), 1'b1, 16'h0000);
            check(q, d[i], "cfg default");
        end
        check(fmt, 1'b0, "format");
        check(dir, 1'b0, "direction");
        check(pins, 4'b0011, "default routing");
        $display("done t_defaults");
    endtask : t_defaults
    task automatic t_cfg_rw();
        logic [15:0] v [8] = '{16'h03FF, 16'h0201, 16'h0155, 16'h02AA,
                               16'hEA98, 16'h0400, 16'h0000, 16'h0300};
        for (int i = 0; i < 8; i++) cfg(3'(i), 1'b0, v[i]);
        for (int i = 0; i < 8; i++) begin
            cfg(3'(i), 1'b1, 16'h0000);
            check(q, v[i], "cfg readback");
        end
        check(ofs[0], 10'h3FF, "offset");
        check(ofs[3], 10'h2AA, "offset");
        check(gc, 16'h0400, "gen ctl");
        check(pc, 16'h0300, "parity ctl");
        check(pins, 4'b1010, "routing");
        $display("done t_cfg_rw");
    endtask : t_cfg_rw
    task automatic t_sw_resets();
        logic [3:0] u [10] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9,
                               4'hC, 4'hD, 4'hE, 4'hF};
        for (int op = 0; op < 8; op++) begin
            pulse(odd_load);
            n_ba  = 0;
            n_ab  = 0;
            n_dma = 0;
            i_host.cmd(OPC_RESET, 3'(op));
            check(n_ba > 0, op inside {1, 3, 7}, "ba clear");
            check(n_ab > 0, op inside {2, 3, 7}, "ab clear");
            check(n_dma > 0, op inside {4, 7}, "dma clear");
            check(valid, !(op inside {1, 3, 7}), "valid");
        end
        check(gc, 16'h0000, "gen ctl restored");
        check(ofs[1], 10'h000, "offset restored");
        cfg(3'h4, 1'b1, 16'h0000);
        check(q, 16'h6420, "routing restored");
        pulse(odd_load);
        for (int k = 0; k < 10; k++) begin
            n_ba  = 0;
            n_ab  = 0;
            n_dma = 0;
            i_host.cmd(u[k], 3'h7);
            check(16'(n_ba + n_ab + n_dma), 16'h0000, "undef op");
        end
        check(valid, 1'b1, "valid kept");
        $display("done t_sw_resets");
    endtask : t_sw_resets
    task automatic t_dir_fmt();
        i_host.cmd(OPC_DMA_DIR, 3'h1);
        check(dir, 1'b0, "dir processor mode");
        cfg(3'h5, 1'b0, 16'h0400);
        i_host.cmd(OPC_DMA_DIR, 3'h7);
        check(dir, 1'b1, "dir read");
        i_host.cmd(OPC_DMA_DIR, 3'h6);
        check(dir, 1'b0, "dir write");
        i_host.cmd(OPC_DMA_DIR, 3'h1);
        check(dir, 1'b1, "dir read");
        i_host.cmd(OPC_STAT_FMT, 3'h6);
        check(fmt, 1'b0, "format 0");
        i_host.cmd(OPC_STAT_FMT, 3'h1);
        check(fmt, 1'b1, "format 1");
        $display("done t_dir_fmt");
    endtask : t_dir_fmt
    task automatic t_tick();
        logic [15:0] g [3] = '{16'h0400, 16'h0600, 16'h0200};
        logic [15:0] e [3] = '{16'h000A, 16'h0005, 16'h0000};
        for (int k = 0; k < 3; k++) begin
            cfg(3'h5, 1'b0, g[k]);
            n_tick = 0;
            repeat (60) @(negedge sys_clk);
            check(16'(n_tick), e[k], "dma tick count");
        end
        $display("done t_tick");
    endtask : t_tick
    task automatic t_status();
        pulse(wpe_set);
        pulse(odd_load);
        stat();
        check(q, 16'h6B68, "status fmt 1");
        i_host.cmd(OPC_RESET, RST_ALL);
        check({fmt, dir}, 2'b11, "fmt dir kept");
        check(gc, 16'h0000, "gen ctl");
        stat();
        check(q, 16'h6A68, "parity kept");
        i_host.cmd(OPC_CLR_WPE, 3'h0);
        pulse(rpe_set);
        stat();
        check(q, 16'h6C68, "parity flags");
        i_host.cmd(OPC_CLR_RPE, 3'h0);
        i_host.cmd(OPC_STAT_FMT, 3'h0);
        stat();
        check(q, 16'h603C, "status fmt 0");
        $display("done t_status");
    endtask : t_status
    task automatic t_hw_reset();
        cfg(3'h5, 1'b0, 16'h0400);
        i_host.cmd(OPC_DMA_DIR, 3'h1);
        i_host.cmd(OPC_STAT_FMT, 3'h1);
        pulse(rpe_set);
        pulse(odd_load);
        n_ba  = 0;
        n_ab  = 0;
        n_dma = 0;
        @(negedge sys_clk) hard_reset_n = 1'b0;
        repeat (6) @(negedge sys_clk);
        hard_reset_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        check({fmt, dir, valid}, 3'b000, "hw reset state");
        check(n_ba > 0 && n_ab > 0 && n_dma > 0, 1'b1, "hw clr");
        check(gc, 16'h0000, "hw reset gen ctl");
        stat();
        check(q, 16'h603C, "hw reset status");
        cfg(3'h4, 1'b1, 16'h0000);
        check(q, 16'h6420, "hw reset routing");
        $display("done t_hw_reset");
    endtask : t_hw_reset
    // ==========================================================
    // Main sequence and watchdog
    initial begin
        rst_n        = 1'b0;
        hard_reset_n = 1'b0;
        {odd_load, wpe_set, rpe_set} = 3'b000;
        flags        = 8'h5A;
        odd_data     = 8'h3C;
        failures     = 0;
        check_count  = 0;
        repeat (20) @(negedge sys_clk);
        rst_n        = 1'b1;
        hard_reset_n = 1'b1;
        repeat (5) @(negedge sys_clk);
        t_defaults();
        t_cfg_rw();
        t_sw_resets();
        t_dir_fmt();
        t_tick();
        t_status();
        t_hw_reset();
        final_report();
    end
    initial begin
        #200000;
        failures++;
        $display("MISMATCH %0t watchdog expired", $time);
        final_report();
    end
endmodule : tb_top
